// *** verilog/ptc_pkg.sv ***
// Constants for the periodic tick counter: register map, fields, resets, divider table.
// Assumes an 8-bit register port with a 3-bit word address.
package ptc_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int            ADDR_W        = 3;
   localparam int            DATA_W        = 8;
   localparam logic [2:0]    ADDR_CTRL     = 3'h0;  // divider_select, source_select
   localparam logic [2:0]    ADDR_COUNT    = 3'h1;  // realtime_count_value, read only
   localparam logic [2:0]    ADDR_LIMIT    = 3'h2;  // match_limit
   localparam logic [2:0]    ADDR_STATUS   = 3'h3;  // match_flag, write one to clear
   localparam logic [2:0]    ADDR_MASK     = 3'h4;  // interrupt enable
   // -----------------------------------------------------------------
   // Fields
   // -----------------------------------------------------------------
   localparam int            DIV_LSB       = 0;     // divider_select in CTRL[3:0]
   localparam int            DIV_W         = 4;
   localparam int            SRC_LSB       = 4;     // source_select in CTRL[5:4]
   localparam int            SRC_W         = 2;
   localparam int            FLAG_BIT      = 0;     // match_flag in STATUS and MASK
   // -----------------------------------------------------------------
   // Reset values and encodings
   // -----------------------------------------------------------------
   localparam logic [7:0]    COUNT_RST     = 8'h00;
   localparam logic [7:0]    LIMIT_RST     = 8'h00;
   localparam logic [3:0]    DIV_OFF       = 4'h0;  // Prescaler off
   localparam logic [1:0]    SRC_LPO       = 2'h0;  // low_power_osc, reset default
   localparam logic [1:0]    SRC_EXT       = 2'h1;  // external_ref_clock
   localparam logic [1:0]    SRC_INT       = 2'h2;  // internal_ref_clock
   localparam logic [3:0]    DEC_FIRST     = 4'h8;  // Codes from here are decimal
   localparam int            PRE_W         = 10;    // Prescaler counter width
   // Terminal counts (divide value minus one), codes 1..7 binary based, 8..15 decimal based
   localparam logic [9:0]    DIV_TABLE [16] = '{
      10'h000, 10'h007, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff,
      10'h000, 10'h001, 10'h004, 10'h009, 10'h013, 10'h031, 10'h063, 10'h3e7};
   // Terminal prescaler count for a divider code (divide value minus one)
   function automatic logic [9:0] ptc_div_term(input logic [3:0] code);
      ptc_div_term = DIV_TABLE[code];
   endfunction
endpackage

// *** verilog/ptc_top.sv ***
// Periodic tick counter: selectable source, prescaler, 8-bit counter with match limit.
// Assumes clock source inputs and mode inputs are synchronous levels on clk.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module ptc_top #(
   parameter int CNT_W = 8                         // Counter width
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [2:0]              addr,       // Register word address
   input  wire logic [7:0]              wdata,      // Write data
   input  wire logic                    wr_en,      // Write strobe
   input  wire logic                    rd_en,      // Read strobe
   output      logic [7:0]              rdata,      // Read data, cycle after rd_en
   input  wire logic                    low_power_osc,      // Source clock level
   input  wire logic                    external_ref_clock, // Source clock level
   input  wire logic                    internal_ref_clock, // Source clock level
   input  wire logic                    wait_mode,  // Processor in wait
   input  wire logic                    stop_shallow, // Processor in shallow stop
   input  wire logic                    stop_deep,  // Processor in deep stop
   input  wire logic                    bdm_active, // Active background debug
   output      logic                    irq,        // Level interrupt
   output      logic                    wakeup      // Wake request in low power
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [3:0]       divider_select_reg;   // Prescaler code, 0 is off
   logic [1:0]       source_select_reg;    // Prescaler input choice
   logic [CNT_W-1:0] count_reg;            // realtime_count_value
   logic [CNT_W-1:0] match_limit_reg;      // Compare value
   logic             match_flag_reg;       // Sticky match event
   logic             irq_en_reg;           // Interrupt mask bit
   logic [9:0]       pre_reg;              // Prescaler counter
   logic             tick_reg;             // Prescaler output pulse
   logic [2:0]       src_d_reg;            // Previous source levels
   logic             src_rise;             // Rising edge on selected source
   logic             src_ok;               // Selected source usable now
   logic             running;              // Counting allowed
   logic             sel_clear;            // Clear of prescaler and counter
   logic             match;                // Compare equal on a tick
   logic             wr_ctrl;
   logic             wr_limit;
   logic             wr_status;
   logic [7:0]       rdata_next;

   // Write decodes
   assign wr_ctrl   = wr_en && (addr == ptc_pkg::ADDR_CTRL);
   assign wr_limit  = wr_en && (addr == ptc_pkg::ADDR_LIMIT);
   assign wr_status = wr_en && (addr == ptc_pkg::ADDR_STATUS);

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   // Holds divider and source codes; reset leaves prescaler off on the oscillator
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divider_select_reg <= ptc_pkg::DIV_OFF;
         source_select_reg  <= ptc_pkg::SRC_LPO;
      end else if (wr_ctrl) begin
         divider_select_reg <= wdata[ptc_pkg::DIV_LSB +: ptc_pkg::DIV_W];
         source_select_reg  <= wdata[ptc_pkg::SRC_LSB +: ptc_pkg::SRC_W];
      end
   end

   // Match limit register, reset to zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         match_limit_reg <= CNT_W'(ptc_pkg::LIMIT_RST);
      end else if (wr_limit) begin
         match_limit_reg <= CNT_W'(wdata);
      end
   end

   // Interrupt enable mask
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_en_reg <= 1'b0;
      end else if (wr_en && (addr == ptc_pkg::ADDR_MASK)) begin
         irq_en_reg <= wdata[ptc_pkg::FLAG_BIT];
      end
   end

   // Any limit write, or a changed select, restarts the prescaler and counter
   assign sel_clear = wr_limit
                      || (wr_ctrl && (wdata[ptc_pkg::DIV_LSB +: ptc_pkg::DIV_W]
                                      != divider_select_reg))
                      || (wr_ctrl && (wdata[ptc_pkg::SRC_LSB +: ptc_pkg::SRC_W]
                                      != source_select_reg));

   // -----------------------------------------------------------------
   // Source selection
   // -----------------------------------------------------------------
   // Previous levels for edge detection of the three sources
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         src_d_reg <= 3'h0;
      end else begin
         src_d_reg <= {internal_ref_clock, external_ref_clock, low_power_osc};
      end
   end

   // Picks the edge of the chosen source; deep stop keeps only the oscillator
   always_comb begin
      src_rise = 1'b0;
      src_ok   = 1'b1;
      unique case (source_select_reg)
         ptc_pkg::SRC_LPO: src_rise = low_power_osc && !src_d_reg[0];
         ptc_pkg::SRC_EXT: begin
            src_rise = external_ref_clock && !src_d_reg[1];
            src_ok   = !stop_deep;
         end
         ptc_pkg::SRC_INT: begin
            src_rise = internal_ref_clock && !src_d_reg[2];
            src_ok   = !stop_deep;
         end
         default: src_ok = 1'b0;        // Unused code selects no source
      endcase
   end

   // Counts on in wait and stop, except a reference clock in deep stop; debug, prescaler off or an unused source code halts it
   assign running = (divider_select_reg != ptc_pkg::DIV_OFF)
                    && !bdm_active
                    && src_ok;

   // -----------------------------------------------------------------
   // Prescaler
   // -----------------------------------------------------------------
   // Divides source edges by the table value plus one and emits one tick pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_reg  <= 10'h000;
         tick_reg <= 1'b0;
      end else if (sel_clear) begin
         pre_reg  <= 10'h000;
         tick_reg <= 1'b0;
      end else if (running && src_rise) begin
         if (pre_reg >= ptc_pkg::ptc_div_term(divider_select_reg)) begin
            pre_reg  <= 10'h000;
            tick_reg <= 1'b1;
         end else begin
            pre_reg  <= pre_reg + 10'h001;
            tick_reg <= 1'b0;
         end
      end else begin
         tick_reg <= 1'b0;              // Held prescaler value while frozen
      end
   end

   // -----------------------------------------------------------------
   // Counter and compare
   // -----------------------------------------------------------------
   // Compare only on a tick that is still allowed to count
   // A clear in the same cycle drops the pending tick, so no flag either
   assign match = tick_reg && !bdm_active && !sel_clear
                  && (count_reg == match_limit_reg);

   // Up-counter, zeroed on match, on limit writes and on select changes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_reg <= CNT_W'(ptc_pkg::COUNT_RST);
      end else if (sel_clear) begin
         count_reg <= CNT_W'(ptc_pkg::COUNT_RST);
      end else if (match) begin
         count_reg <= CNT_W'(ptc_pkg::COUNT_RST);
      end else if (tick_reg && !bdm_active) begin
         count_reg <= count_reg + CNT_W'(1);
      end
   end

   // Sticky match flag; a new match wins over a clear in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         match_flag_reg <= 1'b0;
      end else if (match) begin
         match_flag_reg <= 1'b1;
      end else if (wr_status && wdata[ptc_pkg::FLAG_BIT]) begin
         match_flag_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt and wake
   // -----------------------------------------------------------------
   // Level request while flag and enable are set
   assign irq    = match_flag_reg && irq_en_reg;
   // Same request flagged as a wake source in low-power modes
   assign wakeup = irq && (wait_mode || stop_shallow || stop_deep);

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = 8'h00;
      unique case (addr)
         ptc_pkg::ADDR_CTRL:   rdata_next = {2'h0, source_select_reg, divider_select_reg};
         ptc_pkg::ADDR_COUNT:  rdata_next = 8'(count_reg);
         ptc_pkg::ADDR_LIMIT:  rdata_next = 8'(match_limit_reg);
         ptc_pkg::ADDR_STATUS: rdata_next = {7'h00, match_flag_reg};
         ptc_pkg::ADDR_MASK:   rdata_next = {7'h00, irq_en_reg};
         default:              rdata_next = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         rdata <= rdata_next;
      end else begin
         rdata <= 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // Named steps shared by the properties below
   sequence s_match_tick;
      tick_reg && !bdm_active && !sel_clear && (count_reg == match_limit_reg);
   endsequence
   sequence s_flag_then_zero;
      match_flag_reg && (count_reg == '0);
   endsequence
   // A source edge that closes a prescaler period
   sequence s_pre_wrap;
      running && src_rise && !sel_clear
      && (pre_reg >= ptc_pkg::ptc_div_term(divider_select_reg));
   endsequence
   // One tick with the prescaler back at zero
   sequence s_tick_out;
      tick_reg && (pre_reg == 10'h000);
   endsequence
   // A control write that changes either select field
   sequence s_sel_change;
      wr_ctrl && ((wdata[ptc_pkg::DIV_LSB +: ptc_pkg::DIV_W] != divider_select_reg)
                  || (wdata[ptc_pkg::SRC_LSB +: ptc_pkg::SRC_W] != source_select_reg));
   endsequence
   // Prescaler and counter both at zero
   sequence s_all_zero;
      (count_reg == '0) && (pre_reg == 10'h000);
   endsequence

   // -----------------------------------------------------------------
   // Counter and prescaler checks
   // -----------------------------------------------------------------
   // Match zeroes the count and raises the flag
   chk_match_wraps: assert property (@(posedge clk) disable iff (!nrst)
      s_match_tick |=> s_flag_then_zero)
      else $error("match did not zero count and set flag");
   // A tick below the limit adds one
   chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
      (tick_reg && !bdm_active && !sel_clear && (count_reg != match_limit_reg))
      |=> (count_reg == $past(count_reg) + CNT_W'(1)))
      else $error("count did not step on tick");
   // The last source edge of a period emits a tick
   chk_pre_wrap: assert property (@(posedge clk) disable iff (!nrst)
      s_pre_wrap |=> s_tick_out)
      else $error("prescaler wrap gave no tick");
   // Ticks are single-cycle pulses
   chk_tick_pulse: assert property (@(posedge clk) disable iff (!nrst)
      tick_reg |=> !tick_reg)
      else $error("tick longer than one cycle");
   // Debug freezes the count and swallows ticks
   chk_debug_hold: assert property (@(posedge clk) disable iff (!nrst)
      (bdm_active && !sel_clear) |=> (count_reg == $past(count_reg)) && !tick_reg)
      else $error("count moved during debug");
   // A limit write restarts both counters
   chk_clear_write: assert property (@(posedge clk) disable iff (!nrst)
      wr_limit |=> (count_reg == '0) && (pre_reg == 10'h000))
      else $error("limit write did not clear count");
   // A changed select restarts both counters
   chk_select_clear: assert property (@(posedge clk) disable iff (!nrst)
      s_sel_change |=> s_all_zero)
      else $error("select change did not clear count");
   // The limit takes the written value
   chk_limit_load: assert property (@(posedge clk) disable iff (!nrst)
      wr_limit |=> (match_limit_reg == CNT_W'($past(wdata))))
      else $error("limit write not stored");
   // Writes to the count location leave it alone
   chk_count_ro: assert property (@(posedge clk) disable iff (!nrst)
      (wr_en && (addr == ptc_pkg::ADDR_COUNT) && !tick_reg)
      |=> (count_reg == $past(count_reg)))
      else $error("count write took effect");

   // -----------------------------------------------------------------
   // Source checks
   // -----------------------------------------------------------------
   // No tick without an edge on the chosen source
   chk_no_source: assert property (@(posedge clk) disable iff (!nrst)
      (!src_rise && !sel_clear) |=> !tick_reg)
      else $error("tick without source edge");
   // Reference clocks are unusable in deep stop
   chk_deep_stop: assert property (@(posedge clk) disable iff (!nrst)
      (stop_deep && (source_select_reg != ptc_pkg::SRC_LPO)) |=> !tick_reg)
      else $error("reference clock used in deep stop");
   // Divider code zero keeps the prescaler off
   chk_off_idle: assert property (@(posedge clk) disable iff (!nrst)
      (divider_select_reg == ptc_pkg::DIV_OFF) |=> !tick_reg)
      else $error("prescaler ran while off");

   // -----------------------------------------------------------------
   // Flag, interrupt and read checks
   // -----------------------------------------------------------------
   // Request stays up while no write can lower it
   chk_irq_hold: assert property (@(posedge clk) disable iff (!nrst)
      (irq && !(wr_status && wdata[ptc_pkg::FLAG_BIT]) && !wr_en) |=> irq)
      else $error("interrupt dropped without clear");
   // Flag is sticky until a one is written to it
   chk_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
      (match_flag_reg && !(wr_status && wdata[ptc_pkg::FLAG_BIT])) |=> match_flag_reg)
      else $error("flag lost without clear");
   // Writing a one clears the flag when no match competes
   chk_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
      (wr_status && wdata[ptc_pkg::FLAG_BIT] && !match) |=> !match_flag_reg)
      else $error("flag clear ignored");
   // Pending request wakes from wait and shallow stop
   chk_wake_req: assert property (@(posedge clk) disable iff (!nrst)
      (irq && (wait_mode || stop_shallow)) |-> wakeup)
      else $error("no wake while interrupt pending");
   // Pending request wakes from deep stop
   chk_wake_deep: assert property (@(posedge clk) disable iff (!nrst)
      (irq && stop_deep) |-> wakeup)
      else $error("no wake from deep stop");
   // A count read returns the count of the strobe cycle
   chk_read_count: assert property (@(posedge clk) disable iff (!nrst)
      (rd_en && (addr == ptc_pkg::ADDR_COUNT))
      |=> (rdata == 8'($past(count_reg))))
      else $error("count read wrong");
   // Read data is zero outside the answer cycle
   chk_read_idle: assert property (@(posedge clk) disable iff (!nrst)
      !rd_en |=> (rdata == 8'h00))
      else $error("read data not idle");
endmodule // ptc_top

// *** bench/ptc_top_tb.sv ***
// Self-checking bench for the periodic tick counter: register port, counting, flag, interrupt.
// Assumes ptc_pkg and ptc_top are compiled first; one 40 MHz clock, source clocks made here.
`timescale 1ns/10ps
module ptc_top_tb;
   // ----------------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------------
   logic        clk;                    // Bench clock
   logic        nrst;                   // Active low reset
   logic [2:0]  addr;                   // Register address
   logic [7:0]  wdata;                  // Write data
   logic        wr_en;                  // Write strobe
   logic        rd_en;                  // Read strobe
   logic [7:0]  rdata;                  // Read data
   logic        low_power_osc;          // Source clock levels
   logic        external_ref_clock;
   logic        internal_ref_clock;
   logic        wait_mode;              // Processor mode levels
   logic        stop_shallow;
   logic        stop_deep;
   logic        bdm_active;             // Debug freeze
   logic        irq;                    // Level interrupt
   logic        wakeup;                 // Wake request
   logic        rd_seen;                // Read strobe one cycle ago
   logic [1:0]  sel;                    // Source that the stimulus pulses
   logic [7:0]  exp_q [$];              // Expected read data, oldest first
   int          err_count;              // Mismatches
   int          samples_checked;        // Comparisons made
   int unsigned div_val [16] = '{0, 8, 32, 64, 128, 256, 512, 1024,
                                 1, 2, 5, 10, 20, 50, 100, 1000};   // Divide per code

   // ----------------------------------------------------------------------
   // Design under test
   // ----------------------------------------------------------------------
   ptc_top i_ptc_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .low_power_osc(low_power_osc),
      .external_ref_clock(external_ref_clock), .internal_ref_clock(internal_ref_clock),
      .wait_mode(wait_mode), .stop_shallow(stop_shallow), .stop_deep(stop_deep),
      .bdm_active(bdm_active), .irq(irq), .wakeup(wakeup));

   // Clock, 25 ns period
   always #12.5 clk = ~clk;

   // ----------------------------------------------------------------------
   // Bus, stimulus and compare tasks
   // ----------------------------------------------------------------------
   // One-cycle register write
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // One-cycle register read; the expected value is noted for the monitor
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
   // Rising edges on the chosen source, random noise on the others, then settle
   task automatic edges(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         low_power_osc      <= (sel == 2'h0) ? 1'b1 : 1'($urandom);
         external_ref_clock <= (sel == 2'h1) ? 1'b1 : 1'($urandom);
         internal_ref_clock <= (sel == 2'h2) ? 1'b1 : 1'($urandom);
         @(posedge clk);
         {low_power_osc, external_ref_clock, internal_ref_clock} <= 3'h0;
      end
      repeat (4) @(posedge clk);
   endtask
   // Compare a single-bit output
   task automatic chk_bit(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   // Interrupt and wake levels, looked at away from the clock edge
   task automatic lvl(input logic ei, input logic ew);
      @(negedge clk);
      chk_bit(irq, ei, "irq");
      chk_bit(wakeup, ew, "wakeup");
   endtask
   // Compare read data against the oldest note
   task automatic chk_read(input logic [7:0] got);
      logic [7:0] e;
      samples_checked++;
      if (exp_q.size() == 0) begin
         err_count++;
         $display("MISMATCH t=%0t read data with no expectation", $time);
      end else begin
         e = exp_q.pop_front();
         if (got !== e) begin
            err_count++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, got, e);
         end
      end
   endtask
   // Counts, verdict and end of run
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Monitor: read data stands in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_seen === 1'b1) chk_read(rdata);
      else chk_bit(rdata == 8'h00, 1'b1, "rdata idle");
      rd_seen <= rd_en;
   end

   // Watchdog, about six times the expected run
   initial begin
      #(40000 * 25);
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      clk = 1'b0; nrst = 1'b0; addr = 3'h0; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
      {low_power_osc, external_ref_clock, internal_ref_clock} = 3'h0;
      {wait_mode, stop_shallow, stop_deep, bdm_active} = 4'h0;
      rd_seen = 1'b0; sel = 2'h0; err_count = 0; samples_checked = 0;
      void'($urandom(32'h5ced));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      // Reset state, unmapped read, prescaler off
      rd(ptc_pkg::ADDR_CTRL, 8'h00);
      rd(ptc_pkg::ADDR_LIMIT, 8'h00);
      rd(ptc_pkg::ADDR_STATUS, 8'h00);
      rd(ptc_pkg::ADDR_MASK, 8'h00);
      rd(3'h5, 8'h00);
      edges(4);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      lvl(1'b0, 1'b0);
      $display("test reset done");
      // Counting to the limit, count write ignored, match, interrupt and wake
      wr(ptc_pkg::ADDR_CTRL, 8'h09);
      wr(ptc_pkg::ADDR_MASK, 8'h01);
      wr(ptc_pkg::ADDR_LIMIT, 8'h03);
      edges(6);
      wr(ptc_pkg::ADDR_COUNT, 8'h55);
      rd(ptc_pkg::ADDR_COUNT, 8'h03);
      rd(ptc_pkg::ADDR_STATUS, 8'h00);
      edges(2);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      rd(ptc_pkg::ADDR_STATUS, 8'h01);
      lvl(1'b1, 1'b0);
      wait_mode <= 1'b1;
      lvl(1'b1, 1'b1);
      wait_mode <= 1'b0;
      stop_shallow <= 1'b1;
      lvl(1'b1, 1'b1);
      stop_shallow <= 1'b0;
      stop_deep <= 1'b1;
      lvl(1'b1, 1'b1);
      stop_deep <= 1'b0;
      wr(ptc_pkg::ADDR_MASK, 8'h00);
      lvl(1'b0, 1'b0);
      wr(ptc_pkg::ADDR_MASK, 8'h01);
      lvl(1'b1, 1'b0);
      wr(ptc_pkg::ADDR_STATUS, 8'h01);
      lvl(1'b0, 1'b0);
      rd(ptc_pkg::ADDR_STATUS, 8'h00);
      $display("test match done");
      // Clearing by limit write and select change, not by an equal select write
      edges(4);
      wr(ptc_pkg::ADDR_CTRL, 8'h09);
      rd(ptc_pkg::ADDR_COUNT, 8'h02);
      wr(ptc_pkg::ADDR_LIMIT, 8'h03);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      edges(4);
      wr(ptc_pkg::ADDR_CTRL, 8'h0a);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      wr(ptc_pkg::ADDR_CTRL, 8'h09);
      // Debug freeze and resume
      edges(4);
      bdm_active <= 1'b1;
      edges(6);
      rd(ptc_pkg::ADDR_COUNT, 8'h02);
      bdm_active <= 1'b0;
      edges(2);
      rd(ptc_pkg::ADDR_COUNT, 8'h03);
      $display("test clear and debug done");
      // Sources in stop modes, no source
      wr(ptc_pkg::ADDR_CTRL, 8'h19);
      sel = 2'h1;
      stop_deep <= 1'b1;
      edges(4);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      stop_deep <= 1'b0;
      stop_shallow <= 1'b1;
      edges(4);
      rd(ptc_pkg::ADDR_COUNT, 8'h02);
      wr(ptc_pkg::ADDR_CTRL, 8'h29);
      sel = 2'h2;
      edges(4);
      rd(ptc_pkg::ADDR_COUNT, 8'h02);
      stop_shallow <= 1'b0;
      stop_deep <= 1'b1;
      wr(ptc_pkg::ADDR_CTRL, 8'h09);
      sel = 2'h0;
      edges(4);
      rd(ptc_pkg::ADDR_COUNT, 8'h02);
      stop_deep <= 1'b0;
      wr(ptc_pkg::ADDR_CTRL, 8'h39);
      sel = 2'h3;
      edges(8);
      rd(ptc_pkg::ADDR_COUNT, 8'h00);
      $display("test sources done");
      // Every nonzero divider code, random source, limit zero flags each tick
      wr(ptc_pkg::ADDR_LIMIT, 8'h00);
      for (int c = 1; c < 16; c++) begin
         sel = 2'($urandom % 3);
         wr(ptc_pkg::ADDR_CTRL, {2'h0, sel, 4'(c)});
         wr(ptc_pkg::ADDR_STATUS, 8'h01);
         edges(div_val[c] - 1);
         rd(ptc_pkg::ADDR_STATUS, 8'h00);
         edges(1);
         rd(ptc_pkg::ADDR_STATUS, 8'h01);
      end
      $display("test dividers done");
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
endmodule // ptc_top_tb
